// [verilog/gp_conv_ctrl.sv]
// Control logic of the general converter with its AXI4-Lite register slave
//
// Summary of operation
// - Each conversion yields a 10-bit unsigned code
// - Single-ended bit picks one input or pair
// - Attenuator bit triples the input scale
// - Enabled and idle: track input continuously
// - Writing start ends sampling, begins conversion
// - On completion start clears, sampling resumes
// - Conversion phase lasts about one cycle
// - Constant-load bit adds steady regulator load
// - Dynamic-load bit loads regulator while sampling
// - Chopping takes sample pairs, opposite polarity
// - Mid-scale codes 1FF/200 mark the zero point
// - Mute switches input to centre scale
// - Sign bit inverts input and output polarity
// - Two trim registers, neutral value 0x200
// - Battery channel forces the attenuator on
`timescale 1ns/100ps
`include "gp_conv_cfg.svh"

module gp_conv_ctrl
  import gp_conv_pkg::*;
#(
  parameter int REG_SETTLE_CYC = (`REG_SETTLE_PS / `CLK_PERIOD_PS)
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Analog converter macro, clocked by clk
  input  wire logic [9:0]  adc_code,
  output analog_ctrl_s     analog_ctrl
);

  // Conversion time rounds down but never below one cycle
  localparam int CONV_RAW = `CONV_TIME_PS / `CLK_PERIOD_PS;
  localparam int CONV_CYC = (CONV_RAW < 1) ? 1 : CONV_RAW;
  localparam int CNT_W    = $clog2(REG_SETTLE_CYC + 1);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Byte-lane merge of a write into an old word
  function automatic logic [31:0] wmerge(input logic [31:0] old_w,
                                         input logic [31:0] new_w,
                                         input logic [3:0]  strb);
    logic [31:0] res;
    res = old_w;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Mapped-address check, used by both read and write paths
  function automatic logic mapped(input logic [7:0] a);
    return (a == `OFS_CTRL_PRI) || (a == `OFS_CTRL_SEC) || (a == `OFS_TRIM_POS) ||
           (a == `OFS_TRIM_NEG) || (a == `OFS_RESULT)   || (a == `OFS_STATUS);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bus channel state

  logic        aw_full_q, aw_full_d;
  logic        w_full_q,  w_full_d;
  logic [7:0]  waddr_q,   waddr_d;
  logic [31:0] wdata_q,   wdata_d;
  logic [3:0]  wstrb_q,   wstrb_d;
  logic        bvalid_q,  bvalid_d;
  logic [1:0]  bresp_q,   bresp_d;
  logic        awrdy_q,   awrdy_d;
  logic        wrdy_q,    wrdy_d;
  logic        arrdy_q,   arrdy_d;
  logic        rvalid_q,  rvalid_d;
  logic [31:0] rdata_q,   rdata_d;
  logic [1:0]  rresp_q,   rresp_d;
  logic        wr_fire;

  // Core state
  conv_state_e state_q,   state_d;
  logic        en_q,      en_d;
  logic        start_q,   start_d;
  logic        chop_q,    chop_d;
  logic        se_q,      se_d;
  logic        mute_q,    mute_d;
  logic        inv_q,     inv_d;
  logic        reg_en_q,  reg_en_d;
  logic [2:0]  chan_q,    chan_d;
  logic        atten_q,   atten_d;
  logic        ld20_q,    ld20_d;
  logic        ld10_q,    ld10_d;
  logic [9:0]  trim_p_q,  trim_p_d;
  logic [9:0]  trim_n_q,  trim_n_d;
  logic [9:0]  result_q,  result_d;
  logic        phase_q,   phase_d;
  logic [CNT_W-1:0] settle_q, settle_d;
  logic [CNT_W-1:0] cnt_q,    cnt_d;
  analog_ctrl_s ana_q,    ana_d;

  logic [31:0] ctrl_pri_w, ctrl_sec_w, status_w;

  // Register images, also the base for byte-lane merges
  always_comb begin
    ctrl_pri_w = 32'h0;
    ctrl_pri_w[`BIT_CONV_EN]          = en_q;
    ctrl_pri_w[`BIT_CONV_START]       = start_q;
    ctrl_pri_w[`BIT_CHOP_EN]          = chop_q;
    ctrl_pri_w[`BIT_SINGLE_END]       = se_q;
    ctrl_pri_w[`BIT_CENTRE_IN]        = mute_q;
    ctrl_pri_w[`BIT_POL_INV]          = inv_q;
    ctrl_pri_w[`BIT_REG_EN]           = reg_en_q;
    ctrl_pri_w[`CHAN_MSB:`CHAN_LSB]   = chan_q;
    ctrl_sec_w = 32'h0;
    ctrl_sec_w[`BIT_ATTEN]            = atten_q;
    ctrl_sec_w[`BIT_LOAD_CONST]       = ld20_q;
    ctrl_sec_w[`BIT_LOAD_DYN]         = ld10_q;
    status_w = 32'h0;
    status_w[`BIT_ST_SAMPLE]          = (state_q == ST_SAMPLE);
    status_w[`BIT_ST_CONVERT]         = (state_q == ST_CONVERT);
    status_w[`BIT_ST_SETTLED]         = reg_en_q && (settle_q == CNT_W'(REG_SETTLE_CYC));
    status_w[`BIT_ST_CHOP]            = phase_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave: address and data taken in either order, one write
  // and one read outstanding; unmapped addresses answer SLVERR

  always_comb begin
    aw_full_d = aw_full_q;
    w_full_d  = w_full_q;
    waddr_d   = waddr_q;
    wdata_d   = wdata_q;
    wstrb_d   = wstrb_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    rvalid_d  = rvalid_q;
    rdata_d   = rdata_q;
    rresp_d   = rresp_q;
    wr_fire   = 1'b0;
    if (s_axi_awvalid && awrdy_q) begin
      aw_full_d = 1'b1;
      waddr_d   = s_axi_awaddr;
    end
    if (s_axi_wvalid && wrdy_q) begin
      w_full_d = 1'b1;
      wdata_d  = s_axi_wdata;
      wstrb_d  = s_axi_wstrb;
    end
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    // Commit once both halves are held and no response is pending
    if (aw_full_q && w_full_q && !bvalid_q) begin
      wr_fire   = mapped(waddr_q);
      aw_full_d = 1'b0;
      w_full_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = mapped(waddr_q) ? `RESP_OKAY : `RESP_SLVERR;
    end
    if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    if (s_axi_arvalid && arrdy_q) begin
      rvalid_d = 1'b1;
      rresp_d  = mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
      case (s_axi_araddr)
        `OFS_CTRL_PRI: rdata_d = ctrl_pri_w;
        `OFS_CTRL_SEC: rdata_d = ctrl_sec_w;
        `OFS_TRIM_POS: rdata_d = {22'h0, trim_p_q};
        `OFS_TRIM_NEG: rdata_d = {22'h0, trim_n_q};
        `OFS_RESULT:   rdata_d = {22'h0, result_q};
        `OFS_STATUS:   rdata_d = status_w;
        default:       rdata_d = 32'h0;
      endcase
    end
    // Ready flops are low while a half is held or a response waits
    awrdy_d = !aw_full_d && !bvalid_d;
    wrdy_d  = !w_full_d && !bvalid_d;
    arrdy_d = !rvalid_d;
  end

  // Bus channel registers
  always_ff @(posedge clk) begin
    if (!rstn) begin
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      waddr_q   <= 8'h0;
      wdata_q   <= 32'h0;
      wstrb_q   <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `RESP_OKAY;
      awrdy_q   <= 1'b0;
      wrdy_q    <= 1'b0;
      arrdy_q   <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0;
      rresp_q   <= `RESP_OKAY;
    end else begin
      aw_full_q <= aw_full_d;
      w_full_q  <= w_full_d;
      waddr_q   <= waddr_d;
      wdata_q   <= wdata_d;
      wstrb_q   <= wstrb_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      awrdy_q   <= awrdy_d;
      wrdy_q    <= wrdy_d;
      arrdy_q   <= arrdy_d;
      rvalid_q  <= rvalid_d;
      rdata_q   <= rdata_d;
      rresp_q   <= rresp_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Converter core: register writes, sampling/conversion sequencing

  always_comb begin
    logic [31:0] m;
    logic        eff_inv;
    m         = 32'h0;
    eff_inv   = inv_q ^ (chop_q & phase_q);
    state_d   = state_q;
    en_d      = en_q;
    start_d   = start_q;
    chop_d    = chop_q;
    se_d      = se_q;
    mute_d    = mute_q;
    inv_d     = inv_q;
    reg_en_d  = reg_en_q;
    chan_d    = chan_q;
    atten_d   = atten_q;
    ld20_d    = ld20_q;
    ld10_d    = ld10_q;
    trim_p_d  = trim_p_q;
    trim_n_d  = trim_n_q;
    result_d  = result_q;
    phase_d   = phase_q;
    cnt_d     = cnt_q;
    settle_d  = settle_q;

    // Settling counter restarts whenever the regulator is off
    if (!reg_en_q) begin
      settle_d = '0;
    end else if (settle_q != CNT_W'(REG_SETTLE_CYC)) begin
      settle_d = settle_q + CNT_W'(1);
    end

    // Sequencer
    case (state_q)
      ST_OFF: begin
        start_d = 1'b0;
        if (en_q) begin
          state_d = ST_SAMPLE;
        end
      end
      ST_SAMPLE: begin
        if (!en_q) begin
          state_d = ST_OFF;
        end else if (start_q) begin
          state_d = ST_CONVERT;
          cnt_d   = CNT_W'(CONV_CYC - 1);
        end
      end
      ST_CONVERT: begin
        if (!en_q) begin
          state_d = ST_OFF;
          start_d = 1'b0;
        end else if (cnt_q == '0) begin
          // Output side of the sign inversion; result lands with start clear
          result_d = eff_inv ? ~adc_code : adc_code;
          start_d  = 1'b0;
          state_d  = ST_SAMPLE;
          if (chop_q) begin
            phase_d = ~phase_q;
          end
        end else begin
          cnt_d = cnt_q - CNT_W'(1);
        end
      end
      default: begin
        state_d = ST_OFF;
        start_d = 1'b0;
      end
    endcase

    // Software writes; a start written while busy or disabled is not held
    if (wr_fire) begin
      case (waddr_q)
        `OFS_CTRL_PRI: begin
          m        = wmerge(ctrl_pri_w, wdata_q, wstrb_q);
          en_d     = m[`BIT_CONV_EN];
          chop_d   = m[`BIT_CHOP_EN];
          se_d     = m[`BIT_SINGLE_END];
          mute_d   = m[`BIT_CENTRE_IN];
          inv_d    = m[`BIT_POL_INV];
          reg_en_d = m[`BIT_REG_EN];
          chan_d   = m[`CHAN_MSB:`CHAN_LSB];
          if (!m[`BIT_CHOP_EN]) begin
            phase_d = 1'b0;
          end
          if (m[`BIT_CONV_START] && m[`BIT_CONV_EN] && state_q == ST_SAMPLE) begin
            start_d = 1'b1;
          end
        end
        `OFS_CTRL_SEC: begin
          m       = wmerge(ctrl_sec_w, wdata_q, wstrb_q);
          atten_d = m[`BIT_ATTEN];
          ld20_d  = m[`BIT_LOAD_CONST];
          ld10_d  = m[`BIT_LOAD_DYN];
        end
        `OFS_TRIM_POS: begin
          m        = wmerge({22'h0, trim_p_q}, wdata_q, wstrb_q);
          trim_p_d = m[9:0];
        end
        `OFS_TRIM_NEG: begin
          m        = wmerge({22'h0, trim_n_q}, wdata_q, wstrb_q);
          trim_n_d = m[9:0];
        end
        default: begin
          m = 32'h0;
        end
      endcase
    end

    // Registered control word to the analog macro
    ana_d.regulator_on = reg_en_q;
    ana_d.track        = (state_d == ST_SAMPLE);
    ana_d.convert      = (state_d == ST_CONVERT);
    ana_d.single_ended = se_d;
    ana_d.channel      = chan_d;
    ana_d.attenuate    = atten_d || (chan_d == `CHAN_BATTERY);
    ana_d.load_const   = ld20_d;
    ana_d.load_dyn     = ld10_d && (state_d == ST_SAMPLE);
    ana_d.centre_input = mute_d;
    ana_d.invert       = inv_d ^ (chop_d & phase_d);
    ana_d.trim_pos     = trim_p_d;
    ana_d.trim_neg     = trim_n_d;
  end

  // Core registers; trims come up neutral
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_q  <= ST_OFF;
      en_q     <= 1'b0;
      start_q  <= 1'b0;
      chop_q   <= 1'b0;
      se_q     <= 1'b0;
      mute_q   <= 1'b0;
      inv_q    <= 1'b0;
      reg_en_q <= 1'b0;
      chan_q   <= 3'h0;
      atten_q  <= 1'b0;
      ld20_q   <= 1'b0;
      ld10_q   <= 1'b0;
      trim_p_q <= `TRIM_NEUTRAL;
      trim_n_q <= `TRIM_NEUTRAL;
      result_q <= 10'h0;
      phase_q  <= 1'b0;
      cnt_q    <= '0;
      settle_q <= '0;
      ana_q    <= '{trim_pos: `TRIM_NEUTRAL, trim_neg: `TRIM_NEUTRAL, default: '0};
    end else begin
      state_q  <= state_d;
      en_q     <= en_d;
      start_q  <= start_d;
      chop_q   <= chop_d;
      se_q     <= se_d;
      mute_q   <= mute_d;
      inv_q    <= inv_d;
      reg_en_q <= reg_en_d;
      chan_q   <= chan_d;
      atten_q  <= atten_d;
      ld20_q   <= ld20_d;
      ld10_q   <= ld10_d;
      trim_p_q <= trim_p_d;
      trim_n_q <= trim_n_d;
      result_q <= result_d;
      phase_q  <= phase_d;
      cnt_q    <= cnt_d;
      settle_q <= settle_d;
      ana_q    <= ana_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from flops

  assign s_axi_awready = awrdy_q;
  assign s_axi_wready  = wrdy_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arrdy_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign analog_ctrl   = ana_q;

endmodule

// [verilog/gp_conv_cfg.svh]
// Constants for the general converter control block: offsets, fields, resets, timing
`ifndef GP_CONV_CFG_SVH
`define GP_CONV_CFG_SVH

// Register byte offsets on the AXI4-Lite port
`define OFS_CTRL_PRI     8'h00
`define OFS_CTRL_SEC     8'h04
`define OFS_TRIM_POS     8'h08
`define OFS_TRIM_NEG     8'h0c
`define OFS_RESULT       8'h10
`define OFS_STATUS       8'h14

// converter_control_primary fields
`define BIT_CONV_EN      0
`define BIT_CONV_START   1
`define BIT_CHOP_EN      2
`define BIT_SINGLE_END   3
`define BIT_CENTRE_IN    4
`define BIT_POL_INV      5
`define BIT_REG_EN       6
`define CHAN_LSB         8
`define CHAN_MSB         10

// converter_control_secondary fields
`define BIT_ATTEN        0
`define BIT_LOAD_CONST   1
`define BIT_LOAD_DYN     2

// Status fields
`define BIT_ST_SAMPLE    0
`define BIT_ST_CONVERT   1
`define BIT_ST_SETTLED   2
`define BIT_ST_CHOP      3

// Channel codes: 0..3 port inputs, 4 battery, 5..7 internal voltages
`define CHAN_BATTERY     3'h4

// Reset and neutral values
`define TRIM_NEUTRAL     10'h200
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

// Timing: clock period, conversion time and regulator settling, in picoseconds
`define CLK_PERIOD_PS    100000
`define CONV_TIME_PS     62500
`define REG_SETTLE_PS    20000000

`endif

// [verilog/gp_conv_pkg.sv]
// Types shared by the general converter control block
package gp_conv_pkg;

  // Gray coded along off -> sampling -> conversion
  typedef enum logic [1:0] {
    ST_OFF     = 2'b00,
    ST_SAMPLE  = 2'b01,
    ST_CONVERT = 2'b11
  } conv_state_e;

  // Control word toward the analog converter macro
  typedef struct packed {
    logic       regulator_on;
    logic       track;
    logic       convert;
    logic       single_ended;
    logic [2:0] channel;
    logic       attenuate;
    logic       load_const;
    logic       load_dyn;
    logic       centre_input;
    logic       invert;
    logic [9:0] trim_pos;
    logic [9:0] trim_neg;
  } analog_ctrl_s;

endpackage

// [bench/gp_conv_chk.sv]
// Port-level assertions for the general converter control block
`timescale 1ns/100ps
`include "gp_conv_cfg.svh"
module gp_conv_chk
  import gp_conv_pkg::*;
#(
  parameter int REG_SETTLE_CYC = 200
) (
  input wire logic         clk,
  input wire logic         rstn,
  input wire logic [7:0]   s_axi_awaddr,
  input wire logic         s_axi_awvalid,
  input wire logic         s_axi_awready,
  input wire logic [31:0]  s_axi_wdata,
  input wire logic [3:0]   s_axi_wstrb,
  input wire logic         s_axi_wvalid,
  input wire logic         s_axi_wready,
  input wire logic [7:0]   s_axi_araddr,
  input wire logic         s_axi_arvalid,
  input wire logic         s_axi_arready,
  input wire logic [31:0]  s_axi_rdata,
  input wire logic         s_axi_rvalid,
  input wire analog_ctrl_s analog_ctrl
);
  logic [7:0] rd_addr_d;
  logic [7:0] rd_addr_q;
  logic       start_wr;

  // Address of the read in flight, so read data can be judged by register
  always_comb begin
    rd_addr_d = rd_addr_q;
    if (s_axi_arvalid && s_axi_arready) rd_addr_d = s_axi_araddr;
  end
  always_ff @(posedge clk) begin
    rd_addr_q <= rstn ? rd_addr_d : 8'h00;
  end
  // Only writes with byte lane 0 enabled and both halves on one edge count as a start request
  assign start_wr = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready &&
                    s_axi_awaddr == `OFS_CTRL_PRI && s_axi_wstrb[0] && s_axi_wdata[1:0] == 2'b11;

  ////////////////////////////////////////////////////////////
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rstn);

  a_conv_one_cycle : assert property (
    $rose(analog_ctrl.convert) |=> !analog_ctrl.convert) else $error("Conversion phase outlasted one cycle");
  a_back_to_track : assert property (
    $rose(analog_ctrl.convert) |=> analog_ctrl.track) else $error("Sampling did not resume after conversion");
  a_start_to_convert : assert property (
    start_wr && analog_ctrl.track |-> ##[1:3] analog_ctrl.convert) else $error("Start write did not convert");
  a_convert_cause : assert property (
    $rose(analog_ctrl.convert) |-> $past(analog_ctrl.track)) else $error("Conversion began outside sampling");
  a_phase_excl : assert property (
    !(analog_ctrl.track && analog_ctrl.convert)) else $error("Sampling and conversion overlap");
  a_dyn_sampling : assert property (
    analog_ctrl.load_dyn |-> analog_ctrl.track) else $error("Dynamic load outside sampling");
  a_battery_atten : assert property (
    analog_ctrl.channel == `CHAN_BATTERY |-> analog_ctrl.attenuate) else $error("Battery channel not attenuated");
  a_trim_reset : assert property (
    $rose(rstn) |-> analog_ctrl.trim_pos == `TRIM_NEUTRAL && analog_ctrl.trim_neg == `TRIM_NEUTRAL)
    else $error("Trims not neutral after reset");
  a_result_width : assert property (
    s_axi_rvalid && rd_addr_q == `OFS_RESULT |-> s_axi_rdata[31:10] == 22'h0) else $error("Result wider than 10 bits");

  c_conversion : cover property ($rose(analog_ctrl.convert));
  c_battery    : cover property (analog_ctrl.channel == `CHAN_BATTERY && analog_ctrl.convert);
  c_dyn_load   : cover property (analog_ctrl.load_dyn);
endmodule

bind gp_conv_ctrl gp_conv_chk #(.REG_SETTLE_CYC(REG_SETTLE_CYC)) u_chk (
  .clk(clk), .rstn(rstn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .analog_ctrl(analog_ctrl)
);

// [bench/analog_macro_model.sv]
// Behavioural analog converter macro facing the control block
`timescale 1ns/100ps
module analog_macro_model
  import gp_conv_pkg::*;
#(
  parameter logic [9:0] OFFSET = 10'h003
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire analog_ctrl_s analog_ctrl,
  output logic [9:0]        adc_code
);
  logic [9:0] level;
  logic [9:0] raw;
  logic [9:0] last_d;
  logic [9:0] last_q;

  // Centre scale when muted, else a level marked by channel and scale
  always_comb begin
    level  = analog_ctrl.centre_input ? 10'h1ff : {analog_ctrl.channel, analog_ctrl.attenuate, 6'h15};
    raw    = (analog_ctrl.invert ? ~level : level) + OFFSET;
    last_d = analog_ctrl.convert ? raw : last_q;
  end
  always_ff @(posedge clk) begin
    last_q <= rstn ? last_d : 10'h000;
  end
  // Code valid only while converting; stale code is inverted so it never matches by luck
  assign adc_code = analog_ctrl.convert ? raw : ~last_q;
endmodule

// [bench/test_gp_conv_ctrl.sv]
// Register-level testbench for the general converter control block
`timescale 1ns/100ps
`include "gp_conv_cfg.svh"
module test_gp_conv_ctrl
  import gp_conv_pkg::*;
;
  localparam logic [9:0] OFS = 10'h003;
  logic         clk, rstn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic         s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0]   s_axi_awaddr, s_axi_araddr;
  logic [31:0]  s_axi_wdata, s_axi_rdata, ctrl, rv, r1;
  logic [3:0]   s_axi_wstrb;
  logic [1:0]   s_axi_bresp, s_axi_rresp, resp;
  logic [9:0]   adc_code;
  analog_ctrl_s analog_ctrl;
  int           errors, comparisons, n;
  logic [31:0]  rst_tab [6] = '{32'h0, 32'h0, 32'h200, 32'h200, 32'h0, 32'h0};
  logic [9:0]   trim_tab [3] = '{10'h1fa, 10'h300, 10'h100};

  gp_conv_ctrl #(.REG_SETTLE_CYC(4)) u_dut (
    .clk(clk), .rstn(rstn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .adc_code(adc_code), .analog_ctrl(analog_ctrl)
  );
  analog_macro_model #(.OFFSET(OFS)) u_model (.clk(clk), .rstn(rstn), .analog_ctrl(analog_ctrl), .adc_code(adc_code));

  ////////////////////////////////////////////////////////////
  // Free-running 10 MHz clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Expected code: level plus offset, with the sign turned round on both sides
  function automatic logic [9:0] expv(input logic [9:0] v, input logic inv);
    return inv ? ~(~v + OFS) : v + OFS;
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Write: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // One conversion: set start, poll until it clears, then fetch the result
  task automatic conv(output logic [31:0] res);
    logic [31:0] c;
    int          k;
    k = 0;
    wr(`OFS_CTRL_PRI, ctrl | 32'h2);
    do begin
      rd(`OFS_CTRL_PRI, c, resp);
      k++;
    end while (c[1] !== 1'b0 && k < 20);
    chk(c, ctrl);
    rd(`OFS_RESULT, res, resp);
  endtask

  task automatic close_out;
    $display("Comparisons %0d, errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Hang guard, far above the roughly 1300 cycles the sequence needs
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    close_out;
  end

  ////////////////////////////////////////////////////////////
  initial begin
    {rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0_0000_0000_000f;
    ctrl = 32'h0;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    // Reset values of every register, read-only result, unmapped offset
    for (int i = 0; i < 6; i++) begin
      rd(8'(i * 4), rv, resp);
      chk(rv, rst_tab[i]);
    end
    rd(8'h18, rv, resp);
    chk({rv[31:2], resp}, 32'h2);
    wr(8'h18, 32'h1);
    chk({30'h0, resp}, 32'h2);
    wr(`OFS_RESULT, 32'hffffffff);
    chk({30'h0, resp}, 32'h0);
    rd(`OFS_RESULT, rv, resp);
    chk(rv, 32'h0);
    // Power up; settled and sampling must follow
    ctrl = 32'h49;
    wr(`OFS_CTRL_PRI, ctrl);
    n = 0;
    do begin
      rd(`OFS_STATUS, rv, resp);
      n++;
    end while (rv[2] !== 1'b1 && n < 50);
    chk({rv[31:1], analog_ctrl.track}, 32'h5);
    chk({31'h0, analog_ctrl.regulator_on}, 32'h1);
    // Every scale, mode and channel, battery and internal ones included
    for (int a = 0; a < 2; a++) begin
      for (int s = 0; s < 2; s++) begin
        for (int c = 0; c < 8; c++) begin
          wr(`OFS_CTRL_SEC, 32'(6 | a));
          ctrl = 32'h41 | 32'(s << 3) | 32'(c << 8);
          wr(`OFS_CTRL_PRI, ctrl);
          repeat (16) @(posedge clk);
          chk({29'h0, analog_ctrl.load_const, analog_ctrl.load_dyn, analog_ctrl.single_ended}, 32'(6 | s));
          conv(rv);
          chk(rv, {22'h0, expv({c[2:0], a[0] | (c == 4), 6'h15}, 1'b0)});
        end
      end
    end
    // Offset measurement with both signs; halved sum lands mid-scale
    ctrl = 32'h59;
    wr(`OFS_CTRL_PRI, ctrl);
    conv(r1);
    chk(r1, {22'h0, expv(10'h1ff, 1'b0)});
    ctrl = 32'h79;
    wr(`OFS_CTRL_PRI, ctrl);
    conv(rv);
    chk(rv, {22'h0, expv(10'h1ff, 1'b1)});
    chk((r1 + rv) >> 1, 32'h1ff);
    // Trim values reach the macro unchanged
    for (int i = 0; i < 3; i++) begin
      wr(`OFS_TRIM_POS, {22'h0, trim_tab[i]});
      wr(`OFS_TRIM_NEG, {22'h0, ~trim_tab[i]});
      rd(`OFS_TRIM_NEG, rv, resp);
      chk({rv[21:0], analog_ctrl.trim_pos}, {12'h0, ~trim_tab[i], trim_tab[i]});
      chk({22'h0, analog_ctrl.trim_neg}, {22'h0, ~trim_tab[i]});
    end
    // Byte lane 0 only: the upper trim bits keep their old value
    s_axi_wstrb <= 4'h1;
    wr(`OFS_TRIM_POS, 32'h0000_02ff);
    s_axi_wstrb <= 4'hf;
    rd(`OFS_TRIM_POS, rv, resp);
    chk(rv, 32'h1ff);
    // Chopping: back-to-back pair with opposite polarity
    ctrl = 32'h55;
    wr(`OFS_CTRL_PRI, ctrl);
    conv(r1);
    rd(`OFS_STATUS, rv, resp);
    chk(rv, 32'hd);
    conv(rv);
    chk({r1[15:0], rv[15:0]}, {6'h0, expv(10'h1ff, 1'b0), 6'h0, expv(10'h1ff, 1'b1)});
    close_out;
  end
endmodule
